// file: rtl/tiaepm_evmap.sv
// Performance event to extended external input mapper
`timescale 1ns/1ps
module tiaepm_evmap (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [tiaepm_pkg::EV_MAX:0] pmu_evt_one,
  input wire logic [tiaepm_pkg::EV_MAX:0] pmu_evt_two,
  output logic [tiaepm_pkg::SLOT_MAX:0] ext_in_q
);

  logic [tiaepm_pkg::SLOT_MAX:0] ext_in_d;

  // Two events light both slots; one lights only the first
  always_comb
  begin
    logic [tiaepm_pkg::EV_W-1:0] ev;
    ev = '0;
    ext_in_d = '0;
    for (int e = 1; e <= tiaepm_pkg::EV_MAX; e++)
    begin
      ev = e[tiaepm_pkg::EV_W-1:0];
      if (tiaepm_pkg::first_slot(ev) != '0 && (pmu_evt_one[e] || pmu_evt_two[e]))
        ext_in_d[tiaepm_pkg::first_slot(ev)] = 1'b1;
      if (tiaepm_pkg::second_slot(ev) != '0 && pmu_evt_two[e])
        ext_in_d[tiaepm_pkg::second_slot(ev)] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ext_in_q <= '0;
    else
      ext_in_q <= ext_in_d;
  end

endmodule

// file: rtl/tiaepm_pkg.sv
// Shared constants, states and event-map decoding for the trace idle and event map block
package tiaepm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INSTR = 8'h08;
  localparam logic [7:0] ADDR_EXTOUT = 8'h0c;

  localparam int CTRL_PWRDN = 0;
  localparam int CTRL_PROG = 1;
  localparam int CTRL_TEN = 2;
  localparam int CTRL_OSLOCK = 3;
  localparam int CTRL_W = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h2;

  localparam int STAT_IDLE = 0;
  localparam int STAT_PROG = 1;
  localparam int STAT_ST_LO = 2;

  localparam int NUM_INSTR = 4;
  localparam int NUM_EXTOUT = 2;

  // ----------------------------------------------------------------
  // Instrumentation operations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TIAEPM_OP_CLR = 2'h0,
    TIAEPM_OP_SET = 2'h1,
    TIAEPM_OP_TGL = 2'h2,
    TIAEPM_OP_NOP = 2'h3
  } tiaepm_op_t;

  // ----------------------------------------------------------------
  // Idle sequencer, Gray coded along the drain path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TIAEPM_RUN = 3'h0,
    TIAEPM_STOP = 3'h1,
    TIAEPM_PIPE = 3'h3,
    TIAEPM_MAIN = 3'h2,
    TIAEPM_RSYN = 3'h6,
    TIAEPM_BUS = 3'h7,
    TIAEPM_PTR = 3'h5,
    TIAEPM_IDLE = 3'h4
  } tiaepm_state_t;

  // ----------------------------------------------------------------
  // Performance event numbering
  // ----------------------------------------------------------------
  localparam int EV_W = 7;
  localparam int EV_MAX = 8'h5a;
  localparam int SLOT_W = 6;
  localparam int SLOT_MAX = 8'h32;

  // First extended input slot of an event, zero when unmapped
  function automatic logic [SLOT_W-1:0] first_slot(input logic [EV_W-1:0] ev);
    logic [EV_W-1:0] s;
    s = 7'h00;
    if (ev >= 7'h01 && ev <= 7'h03) s = ev;
    else if (ev >= 7'h04 && ev <= 7'h08) s = ev + 7'h01;
    else if (ev >= 7'h09 && ev <= 7'h10) s = ev + 7'h02;
    else if (ev == 7'h12) s = 7'h13;
    else if (ev >= 7'h40 && ev <= 7'h43) s = ev - 7'h2c;
    else if (ev == 7'h44) s = 7'h19;
    else if (ev >= 7'h45 && ev <= 7'h55) s = ev - 7'h2b;
    else if (ev >= 7'h56 && ev <= 7'h57) s = ev - 7'h2a;
    else if (ev >= 7'h58 && ev <= 7'h5a) s = ev - 7'h29;
    return s[SLOT_W-1:0];
  endfunction

  // Second slot for events that can occur twice per cycle
  function automatic logic [SLOT_W-1:0] second_slot(input logic [EV_W-1:0] ev);
    logic [SLOT_W-1:0] s;
    case (ev)
      7'h08: s = 6'h0a;
      7'h43: s = 6'h18;
      7'h44: s = 6'h32;
      7'h55: s = 6'h2b;
      7'h57: s = 6'h2e;
      default: s = 6'h00;
    endcase
    return s;
  endfunction

endpackage

// file: rtl/tiaepm_sync.sv
// Two-flop level synchroniser for asynchronous inputs
`timescale 1ns/1ps
module tiaepm_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// file: rtl/tiaepm_top.sv
// Trace unit idle control, instrumentation resources and event mapping
//
// Overview of operation
// - Four instrumentation resources, changed by instrumentation instructions from the core.
// - A cancelled instrumentation instruction leaves the resources untouched.
// - Idle entry: stop, pipe drain, main FIFO, resync FIFO, trace bus.
// - Finally the resync FIFO pointers both return to zero.
// - After reset the unit sits in idle.
// - Power-down, programming, enable low, OS lock, wait request or no debug enable cause idle.
// - Status programming bit reads 1 only when programming, power-down or OS lock is requested and idle reached.
// - A withdrawn idle request is held until the sequence completes.
// - Each mapped event drives one input, double events two inputs; unmapped event numbers drive none.
// - Single-slot event numbering follows the fixed mapping table.
// - Five events map to a first and a second input slot.
// - External outputs reach the monitor only via the cross-trigger unit.
//
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module tiaepm_top (
  input wire logic sys_clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Debug enable pins
  input wire logic noninvasive_debug_enable,
  input wire logic invasive_debug_enable,
  // Core side
  input wire logic wait_for_interrupt_request,
  input wire logic instr_valid,
  input wire logic [1:0] instr_sel,
  input wire logic [1:0] instr_op,
  input wire logic instr_cancel,
  output logic idle_complete,
  output logic trace_run,
  output logic [tiaepm_pkg::NUM_INSTR-1:0] instr_res,
  // Drain status
  input wire logic pipe_empty,
  input wire logic main_fifo_empty,
  input wire logic resync_fifo_empty,
  input wire logic bus_accepted,
  input wire logic resync_ptr_zero,
  output logic resync_ptr_clear,
  // Event paths
  input wire logic [tiaepm_pkg::EV_MAX:0] pmu_evt_one,
  input wire logic [tiaepm_pkg::EV_MAX:0] pmu_evt_two,
  output logic [tiaepm_pkg::SLOT_MAX:0] ext_in,
  output logic [tiaepm_pkg::NUM_EXTOUT-1:0] trace_extout
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Resync FIFO flags live on the trace bus clock, so they cross here
  // Lane order inside the synchroniser vector
  localparam int SY_NID = 0;
  localparam int SY_ID = 1;
  localparam int SY_RSYN = 2;
  localparam int SY_BUS = 3;
  localparam int SY_PTR = 4;
  localparam int SY_W = 5;

  logic [SY_W-1:0] async_vec;
  logic [SY_W-1:0] sync_vec;
  logic nid_s;
  logic id_s;
  logic rsyn_empty_s;
  logic bus_acc_s;
  logic ptr_zero_s;

  assign async_vec = {resync_ptr_zero, bus_accepted, resync_fifo_empty,
                      invasive_debug_enable, noninvasive_debug_enable};

  tiaepm_sync #(
    .W(SY_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(async_vec),
    .sync_out(sync_vec)
  );

  assign nid_s = sync_vec[SY_NID];
  assign id_s = sync_vec[SY_ID];
  assign rsyn_empty_s = sync_vec[SY_RSYN];
  assign bus_acc_s = sync_vec[SY_BUS];
  assign ptr_zero_s = sync_vec[SY_PTR];

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [tiaepm_pkg::CTRL_W-1:0] ctrl_q;
  logic [tiaepm_pkg::NUM_EXTOUT-1:0] extout_q;
  logic [tiaepm_pkg::NUM_INSTR-1:0] instr_q;
  logic prog_hold_q;
  logic wb_req;
  logic wb_wr;
  logic [31:0] rd_d;
  tiaepm_pkg::tiaepm_state_t state_q;
  tiaepm_pkg::tiaepm_state_t state_d;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];

  // Write strobe for one register offset, shared by every writable register
  function automatic logic reg_hit(input logic wr, input logic [7:0] adr, input logic [7:0] target);
    return wr && (adr == target);
  endfunction

  // Answer one cycle after the request, drop the cycle after
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_req;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ctrl_q <= tiaepm_pkg::CTRL_RST;
    else if (reg_hit(wb_wr, wb_adr_i, tiaepm_pkg::ADDR_CTRL))
      ctrl_q <= wb_dat_i[tiaepm_pkg::CTRL_W-1:0];
  end

  // Held for software; the cross-trigger unit syncs and edge-detects them
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      extout_q <= '0;
    else if (reg_hit(wb_wr, wb_adr_i, tiaepm_pkg::ADDR_EXTOUT))
      extout_q <= wb_dat_i[tiaepm_pkg::NUM_EXTOUT-1:0];
  end

  assign trace_extout = extout_q;

  // ----------------------------------------------------------------
  // Idle request and programming hold
  // ----------------------------------------------------------------
  logic prog_eff;
  logic idle_req;
  logic in_idle;

  assign in_idle = (state_q == tiaepm_pkg::TIAEPM_IDLE);

  // A programming bit pulsed 1-0 keeps its effect until idle is reached
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      prog_hold_q <= 1'b0;
    else if (ctrl_q[tiaepm_pkg::CTRL_PROG] && !in_idle)
      prog_hold_q <= 1'b1;
    else if (in_idle)
      prog_hold_q <= 1'b0;
  end

  assign prog_eff = ctrl_q[tiaepm_pkg::CTRL_PROG] || prog_hold_q;

  assign idle_req = ctrl_q[tiaepm_pkg::CTRL_PWRDN]
                 || prog_eff
                 || !ctrl_q[tiaepm_pkg::CTRL_TEN]
                 || ctrl_q[tiaepm_pkg::CTRL_OSLOCK]
                 || wait_for_interrupt_request
                 || (!nid_s && !id_s);

  // ----------------------------------------------------------------
  // Idle entry sequencer
  // ----------------------------------------------------------------
  // Once started the drain runs to the end even if the request goes away
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      tiaepm_pkg::TIAEPM_RUN:
        if (idle_req)
          state_d = tiaepm_pkg::TIAEPM_STOP;
      tiaepm_pkg::TIAEPM_STOP:
        state_d = tiaepm_pkg::TIAEPM_PIPE;
      tiaepm_pkg::TIAEPM_PIPE:
        if (pipe_empty)
          state_d = tiaepm_pkg::TIAEPM_MAIN;
      tiaepm_pkg::TIAEPM_MAIN:
        if (main_fifo_empty)
          state_d = tiaepm_pkg::TIAEPM_RSYN;
      tiaepm_pkg::TIAEPM_RSYN:
        if (rsyn_empty_s)
          state_d = tiaepm_pkg::TIAEPM_BUS;
      tiaepm_pkg::TIAEPM_BUS:
        if (bus_acc_s)
          state_d = tiaepm_pkg::TIAEPM_PTR;
      tiaepm_pkg::TIAEPM_PTR:
        if (ptr_zero_s)
          state_d = tiaepm_pkg::TIAEPM_IDLE;
      tiaepm_pkg::TIAEPM_IDLE:
        if (!idle_req)
          state_d = tiaepm_pkg::TIAEPM_RUN;
      // Stray codes land in idle, the one state safe for power removal
      default:
        state_d = tiaepm_pkg::TIAEPM_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_q <= tiaepm_pkg::TIAEPM_IDLE;
    else
      state_q <= state_d;
  end

  // Level request, held until the far side reports both pointers at zero
  assign resync_ptr_clear = (state_q == tiaepm_pkg::TIAEPM_PTR);
  assign idle_complete = in_idle;
  assign trace_run = (state_q == tiaepm_pkg::TIAEPM_RUN);

  // ----------------------------------------------------------------
  // Instrumentation resources
  // ----------------------------------------------------------------
  // Cancel is predicted alongside the traced instruction
  // Only taken while trace runs; during the drain nothing is traced
  logic instr_take;

  assign instr_take = instr_valid && !instr_cancel && trace_run;

  for (genvar r = 0; r < tiaepm_pkg::NUM_INSTR; r++)
  begin : g_instr
    always_ff @(posedge sys_clk)
    begin
      if (rst)
        instr_q[r] <= 1'b0;
      else if (instr_take && instr_sel == 2'(r))
      begin
        case (tiaepm_pkg::tiaepm_op_t'(instr_op))
          tiaepm_pkg::TIAEPM_OP_CLR: instr_q[r] <= 1'b0;
          tiaepm_pkg::TIAEPM_OP_SET: instr_q[r] <= 1'b1;
          tiaepm_pkg::TIAEPM_OP_TGL: instr_q[r] <= !instr_q[r];
          default: instr_q[r] <= instr_q[r];
        endcase
      end
    end
  end

  assign instr_res = instr_q;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_d = 32'h0000_0000;
    case (wb_adr_i)
      tiaepm_pkg::ADDR_CTRL:
        rd_d[tiaepm_pkg::CTRL_W-1:0] = ctrl_q;
      tiaepm_pkg::ADDR_STATUS:
      begin
        rd_d[tiaepm_pkg::STAT_IDLE] = in_idle;
        rd_d[tiaepm_pkg::STAT_PROG] = in_idle && (prog_eff || ctrl_q[tiaepm_pkg::CTRL_PWRDN]
                                     || ctrl_q[tiaepm_pkg::CTRL_OSLOCK]);
        rd_d[tiaepm_pkg::STAT_ST_LO +: 3] = state_q;
      end
      tiaepm_pkg::ADDR_INSTR:
        rd_d[tiaepm_pkg::NUM_INSTR-1:0] = instr_q;
      tiaepm_pkg::ADDR_EXTOUT:
        rd_d[tiaepm_pkg::NUM_EXTOUT-1:0] = extout_q;
      default:
        rd_d = 32'h0000_0000;
    endcase
  end

  // Registered so the read word stands together with ack
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      wb_dat_o <= 32'h0000_0000;
    else if (wb_req)
      wb_dat_o <= rd_d;
  end

  // ----------------------------------------------------------------
  // Event mapping
  // ----------------------------------------------------------------
  // Registered there, so the inputs follow the events by one cycle
  tiaepm_evmap u_evmap (
    .sys_clk(sys_clk),
    .rst(rst),
    .pmu_evt_one(pmu_evt_one),
    .pmu_evt_two(pmu_evt_two),
    .ext_in_q(ext_in)
  );

endmodule

// file: sim/testbench.sv
// Self-checking bench for the trace idle and event map block
`timescale 1ns/1ps
module testbench;
  logic sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, idle_complete, trace_run;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, lag, instr_res, res_m;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic noninvasive_debug_enable, invasive_debug_enable, wait_for_interrupt_request;
  logic instr_valid, instr_cancel, pipe_empty, main_fifo_empty, resync_fifo_empty;
  logic bus_accepted, resync_ptr_zero, resync_ptr_clear;
  logic [1:0] instr_sel, instr_op, trace_extout, xo;
  logic [tiaepm_pkg::EV_MAX:0] pmu_evt_one, pmu_evt_two;
  logic [tiaepm_pkg::SLOT_MAX:0] ext_in, exp_cur;
  logic [3:0] ctl_tab [4] = '{4'h5, 4'h6, 4'h0, 4'hc};
  int err_total, num_checks, n;
  tiaepm_top DUT (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .noninvasive_debug_enable, .invasive_debug_enable, .wait_for_interrupt_request, .instr_valid,
    .instr_sel, .instr_op, .instr_cancel, .idle_complete, .trace_run, .instr_res, .pipe_empty, .main_fifo_empty,
    .resync_fifo_empty, .bus_accepted, .resync_ptr_zero, .resync_ptr_clear, .pmu_evt_one, .pmu_evt_two, .ext_in,
    .trace_extout);
  tiaepm_partner u_far (.sys_clk, .rst, .trace_run, .resync_ptr_clear, .lag, .pipe_empty, .main_fifo_empty,
    .resync_fifo_empty, .bus_accepted, .resync_ptr_zero);
  // -------------------------------------------------
  // Helpers
  // -------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge sys_clk);
    k = 1;
    while (wb_ack_o !== 1'b1 && k < 20)
    begin
      @(posedge sys_clk);
      k++;
    end
    check({63'h0, k < 20}, 64'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Bounded wait on the run or the idle indication
  task automatic wait_on(input logic want_run);
    int k;
    k = 0;
    while ((want_run ? trace_run : idle_complete) !== 1'b1 && k < 200)
    begin
      @(posedge sys_clk);
      k++;
    end
    check({63'h0, k < 200}, 64'h1);
  endtask
  function automatic logic [6:0] first_of(input logic [6:0] e);
    if (e >= 7'h58) return e - 7'h29;
    if (e >= 7'h56) return e - 7'h2a;
    if (e >= 7'h45) return e - 7'h2b;
    if (e == 7'h44) return 7'h19;
    if (e >= 7'h40) return e - 7'h2c;
    if (e == 7'h12) return 7'h13;
    if (e >= 7'h09 && e <= 7'h10) return e + 7'h02;
    if (e >= 7'h04 && e <= 7'h08) return e + 7'h01;
    if (e <= 7'h03) return e;
    return 7'h00;
  endfunction
  function automatic logic [6:0] second_of(input logic [6:0] e);
    case (e)
      7'h08: return 7'h0a;
      7'h43: return 7'h18;
      7'h44: return 7'h32;
      7'h55: return 7'h2b;
      7'h57: return 7'h2e;
      default: return 7'h00;
    endcase
  endfunction
  // -------------------------------------------------
  // Run
  // -------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    finish_test();
  end
  initial
  begin
    {rst, noninvasive_debug_enable, invasive_debug_enable} = 3'h7;
    {wb_cyc_i, wb_stb_i, wb_we_i, wait_for_interrupt_request, instr_valid, instr_cancel} = 6'h0;
    {wb_adr_i, wb_dat_i, instr_sel, instr_op, lag, res_m} = '0;
    wb_sel_i = 4'hf;
    {pmu_evt_one, pmu_evt_two, exp_cur} = '0;
    n = $urandom(32'h3f3dbc27);
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    wb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h13);
    wb(1'b1, 8'h10, 32'hffffffff);
    wb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    $display("test done: reset");
    wb(1'b1, 8'h00, 32'h4);
    wait_on(1'b1);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge sys_clk);
      check(instr_res, res_m);
      if (instr_valid && !instr_cancel)
        case (instr_op)
          2'h0: res_m[instr_sel] = 1'b0;
          2'h1: res_m[instr_sel] = 1'b1;
          2'h2: res_m[instr_sel] = !res_m[instr_sel];
          default: ;
        endcase
      instr_valid <= i < 39 ? 1'($urandom) : 1'b0;
      instr_cancel <= 1'($urandom);
      instr_sel <= 2'($urandom);
      instr_op <= 2'($urandom);
    end
    wb(1'b0, 8'h08, 32'h0);
    check(rd, {28'h0, res_m});
    xo = 2'($urandom);
    wb(1'b1, 8'h0c, {30'h0, xo});
    check(trace_extout, xo);
    $display("test done: instrumentation");
    for (int c = 0; c < 6; c++)
    begin
      lag <= 4'($urandom % 8);
      if (c < 4)
        wb(1'b1, 8'h00, {28'h0, ctl_tab[c]});
      else if (c == 4)
        wait_for_interrupt_request <= 1'b1;
      else
        {noninvasive_debug_enable, invasive_debug_enable} <= 2'b00;
      wait_on(1'b0);
      wb(1'b0, 8'h04, 32'h0);
      check(rd[1:0], {c != 2 && c < 4, 1'b1});
      wb(1'b0, 8'h00, 32'h0);
      check(rd, {28'h0, c < 4 ? ctl_tab[c] : 4'h4});
      wait_for_interrupt_request <= 1'b0;
      {noninvasive_debug_enable, invasive_debug_enable} <= 2'b11;
      wb(1'b1, 8'h00, 32'h4);
      wait_on(1'b1);
    end
    $display("test done: idle causes");
    lag <= 4'h7;
    wb(1'b1, 8'h00, 32'h6);
    wb(1'b1, 8'h00, 32'h4);
    check(trace_run, 1'b0);
    wait_on(1'b0);
    wait_on(1'b1);
    $display("test done: withdrawn request");
    for (int j = 0; j < 40; j++)
    begin
      @(posedge sys_clk);
      check(ext_in, exp_cur);
      exp_cur = '0;
      for (int e = 0; e <= tiaepm_pkg::EV_MAX; e++)
      begin
        if (pmu_evt_one[e] || pmu_evt_two[e])
          exp_cur[first_of(7'(e))] = 1'b1;
        if (pmu_evt_two[e])
          exp_cur[second_of(7'(e))] = 1'b1;
      end
      exp_cur[0] = 1'b0;
      for (int e = 0; e <= tiaepm_pkg::EV_MAX; e++)
      begin
        n = j == 0 ? 1 : j == 1 ? 2 : j > 37 ? 0 : $urandom % 4;
        pmu_evt_one[e] <= n == 1;
        pmu_evt_two[e] <= n == 2 && second_of(7'(e)) != 7'h00;
      end
    end
    $display("test done: events");
    finish_test();
  end
endmodule

// file: sim/tiaepm_monitor.sv
// Concurrent checks on the ports of the trace idle and event map block
`timescale 1ns/1ps
module tiaepm_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [1:0] instr_sel,
  input wire logic [1:0] instr_op,
  input wire logic instr_cancel,
  input wire logic wait_for_interrupt_request,
  input wire logic idle_complete,
  input wire logic trace_run,
  input wire logic [tiaepm_pkg::NUM_INSTR-1:0] instr_res,
  input wire logic resync_ptr_clear,
  input wire logic [tiaepm_pkg::EV_MAX:0] pmu_evt_one,
  input wire logic [tiaepm_pkg::EV_MAX:0] pmu_evt_two,
  input wire logic [tiaepm_pkg::SLOT_MAX:0] ext_in
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // -------------------------------------------------
  // Properties
  // -------------------------------------------------
  sequence s_taken;
    instr_valid && !instr_cancel && trace_run;
  endsequence
  sequence s_drain;
    !idle_complete [*6];
  endsequence
  property p_rst_idle;
    $fell(rst) |-> idle_complete && !trace_run;
  endproperty
  property p_res_hold;
    !(instr_valid && !instr_cancel && trace_run) |=> $stable(instr_res);
  endproperty
  property p_res_set;
    s_taken ##0 instr_op == 2'h1 |=> instr_res[$past(instr_sel)];
  endproperty
  property p_drain;
    $fell(trace_run) |-> s_drain;
  endproperty
  property p_ptr_last;
    $rose(idle_complete) |-> $past(resync_ptr_clear);
  endproperty
  property p_excl;
    !(idle_complete && trace_run);
  endproperty
  property p_wfi;
    wait_for_interrupt_request && trace_run |=> !trace_run;
  endproperty
  property p_no_evt;
    pmu_evt_one == '0 && pmu_evt_two == '0 |=> ext_in == '0;
  endproperty
  property p_map;
    pmu_evt_one[7'h12] |=> ext_in[6'h13];
  endproperty
  property p_dual;
    pmu_evt_two[7'h44] |=> ext_in[6'h19] && ext_in[6'h32];
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
  a_res_hold: assert property (p_res_hold) else $error("resources changed");
  a_res_set: assert property (p_res_set) else $error("resource not set");
  a_drain: assert property (p_drain) else $error("idle entry too short");
  a_ptr_last: assert property (p_ptr_last) else $error("idle before pointer clear");
  a_excl: assert property (p_excl) else $error("idle while running");
  a_wfi: assert property (p_wfi) else $error("wait request ignored");
  a_no_evt: assert property (p_no_evt) else $error("input without event");
  a_map: assert property (p_map) else $error("event map wrong");
  a_dual: assert property (p_dual) else $error("dual event map wrong");
endmodule
bind tiaepm_top tiaepm_monitor u_mon (.sys_clk, .rst, .instr_valid, .instr_sel, .instr_op, .instr_cancel,
  .wait_for_interrupt_request, .idle_complete, .trace_run, .instr_res, .resync_ptr_clear, .pmu_evt_one,
  .pmu_evt_two, .ext_in);

// file: sim/tiaepm_partner.sv
// Far-side model: trace pipe, FIFOs and trace bus sink that drain after trace stops
`timescale 1ns/1ps
module tiaepm_partner (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic trace_run,
  input wire logic resync_ptr_clear,
  input wire logic [3:0] lag,
  output logic pipe_empty,
  output logic main_fifo_empty,
  output logic resync_fifo_empty,
  output logic bus_accepted,
  output logic resync_ptr_zero
);
  logic [7:0] cnt_q;
  logic [7:0] step;
  logic zero_q;
  // -------------------------------------------------
  // Drain timing
  // -------------------------------------------------
  // A zero lag drains in one cycle; larger lags stall every stage
  assign step = {4'h0, lag};
  always_ff @(posedge sys_clk)
  begin
    if (rst || trace_run)
      cnt_q <= 8'h00;
    else if (cnt_q != 8'hff)
      cnt_q <= cnt_q + 8'h01;
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst || trace_run)
      zero_q <= 1'b0;
    else if (resync_ptr_clear)
      zero_q <= 1'b1;
  end
  assign pipe_empty = cnt_q > step;
  assign main_fifo_empty = cnt_q > step * 8'h02;
  assign resync_fifo_empty = cnt_q > step * 8'h03;
  assign bus_accepted = cnt_q > step * 8'h04;
  assign resync_ptr_zero = zero_q;
endmodule
